/* rtl/wsc_pkg.sv */
// Behaviour
// - count stays between zero and wrap limit
// - rising request edges count; steady levels do not
// - unit step up past limit gives zero; unit step down past zero gives limit
// - each event moves count by increment size
// - load strobe forces count to load value modulo limit plus one
// - async clear forces zero without any edge
// - wrap acts as modulo limit plus one
// - wide variant 32-bit, narrow variant 8-bit
package wsc_pkg;
  // ----------------------------------------
  // widths of the two variants
  // ----------------------------------------
  localparam int unsigned NARROW_WIDTH = 8;   // byte variant
  localparam int unsigned WIDE_WIDTH   = 32;  // word variant
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic COUNT_RESET_BIT = 1'b0;    // count bits after reset or clear
  localparam logic REQ_RESET_BIT   = 1'b0;    // request history after reset
endpackage : wsc_pkg

/* rtl/wsc_counter.sv */
`timescale 1ns/100ps
module wsc_counter #(
  parameter int unsigned WIDTH = wsc_pkg::NARROW_WIDTH  // 8 narrow, 32 wide
) (
  input  wire logic             clk,                // 250 MHz system clock
  input  wire logic             rst_n,              // async reset, active low
  input  wire logic             async_clear,        // async clear to zero, active high
  input  wire logic             load_strobe,        // force count to load_value modulo wrap_limit plus one
  input  wire logic [WIDTH-1:0] load_value,         // preset value
  input  wire logic             increment_request,  // count up on rising edge
  input  wire logic             decrement_request,  // count down on rising edge
  input  wire logic [WIDTH-1:0] increment_size,     // step per event
  input  wire logic [WIDTH-1:0] wrap_limit,         // highest count value
  output logic      [WIDTH-1:0] count_output        // current count
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  // zero pattern built from the package reset bit
  localparam logic [WIDTH-1:0] COUNT_ZERO = {WIDTH{wsc_pkg::COUNT_RESET_BIT}};  // reset count

  logic             inc_prev_r;   // increment request last cycle
  logic             dec_prev_r;   // decrement request last cycle
  logic             inc_edge;     // rising edge on increment request
  logic             dec_edge;     // rising edge on decrement request
  logic [WIDTH:0]   modulus;      // wrap limit plus one, one bit wider
  logic [WIDTH:0]   cnt_m;        // count reduced into range
  logic [WIDTH:0]   step_m;       // step reduced into range
  logic [WIDTH:0]   load_m;       // load value reduced into range
  logic [WIDTH:0]   up_sum;       // count plus step
  logic [WIDTH-1:0] count_r;      // count register
  logic [WIDTH-1:0] count_nxt;    // next count on a clock edge

  // ----------------------------------------
  // request edge detection
  // ----------------------------------------
  // history follows the inputs even while forced, so edges seen under
  // load or clear are consumed and not replayed afterwards
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inc_prev_r <= wsc_pkg::REQ_RESET_BIT;
      dec_prev_r <= wsc_pkg::REQ_RESET_BIT;
    end else begin
      inc_prev_r <= increment_request;
      dec_prev_r <= decrement_request;
    end
  end

  // a request already high when reset lets go counts once at the first edge,
  // because the history comes out of reset low
  assign inc_edge = increment_request & ~inc_prev_r;
  assign dec_edge = decrement_request & ~dec_prev_r;

  // ----------------------------------------
  // modulo arithmetic
  // ----------------------------------------
  // modulus is one bit wider so a limit of all ones still wraps cleanly;
  // the remainders cost area but give exact results for any step size
  // limitation: the wide variant builds three 33-bit remainders, a long
  // combinational path that sets the highest usable clock rate
  assign modulus = {1'b0, wrap_limit} + {{WIDTH{1'b0}}, 1'b1};
  assign cnt_m   = {1'b0, count_r} % modulus;
  assign step_m  = {1'b0, increment_size} % modulus;
  assign load_m  = {1'b0, load_value} % modulus;
  assign up_sum  = cnt_m + step_m;

  // next count from forcing inputs and request edges
  // clear is not decoded here; the count register below overrides it
  always_comb begin
    count_nxt = count_r;
    if (load_strobe) begin
      count_nxt = load_m[WIDTH-1:0];
    end else if (inc_edge && dec_edge) begin
      count_nxt = count_r;
    end else if (inc_edge) begin
      // sum ran past the limit: take one modulus off
      if (up_sum >= modulus) begin
        count_nxt = WIDTH'(up_sum - modulus);
      end else begin
        count_nxt = up_sum[WIDTH-1:0];
      end
    end else if (dec_edge) begin
      // result stays at or above zero: plain subtraction
      if (cnt_m >= step_m) begin
        count_nxt = WIDTH'(cnt_m - step_m);
      end else begin
        count_nxt = WIDTH'(cnt_m + modulus - step_m);
      end
    end else begin
      count_nxt = count_r;
    end
  end

  // ----------------------------------------
  // count register
  // ----------------------------------------
  // clear acts without the clock and wins over everything but reset
  // hazard: a glitch on the clear line zeroes the count at once, so it
  // must come from a clean, glitch-free source
  always_ff @(posedge clk or negedge rst_n or posedge async_clear) begin
    if (!rst_n) begin
      count_r <= COUNT_ZERO;
    end else if (async_clear) begin
      count_r <= COUNT_ZERO;
    end else begin
      count_r <= count_nxt;
    end
  end

  // output straight from the count flip-flops
  assign count_output = count_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // most checks look only at cycles that no forcing input disturbs
  logic plain_cycle;  // no forcing input active
  assign plain_cycle = !async_clear && !load_strobe;

  // a counting event keeps the count within the range
  range_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (plain_cycle && (inc_edge || dec_edge) && $stable(wrap_limit)) |=> (async_clear || count_r <= $past(wrap_limit)))
    else $error("count left the range after a counting event");

  // without a request edge the count stays put
  level_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (plain_cycle && !inc_edge && !dec_edge) |=> (async_clear || count_r == $past(count_r)))
    else $error("count moved without a request edge");

  // unit step up from the limit lands on zero
  up_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (plain_cycle && inc_edge && !dec_edge && count_r == wrap_limit && increment_size == WIDTH'(1))
    |=> (async_clear || count_r == COUNT_ZERO))
    else $error("up count past limit did not give zero");

  // unit step down from zero lands on the limit
  down_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (plain_cycle && dec_edge && !inc_edge && count_r == COUNT_ZERO && increment_size == WIDTH'(1))
    |=> (async_clear || count_r == $past(wrap_limit)))
    else $error("down count past zero did not give limit");

  // up step inside the range adds the step size
  step_up_a: assert property (@(posedge clk) disable iff (!rst_n)
    (plain_cycle && inc_edge && !dec_edge
      && ({1'b0, count_r} + {1'b0, increment_size}) <= {1'b0, wrap_limit})
    |=> (async_clear || count_r == WIDTH'($past(count_r) + $past(increment_size))))
    else $error("up step did not add the increment size");

  // a preset inside the range is taken as is
  load_force_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!async_clear && load_strobe && load_value <= wrap_limit)
    |=> (async_clear || count_r == $past(load_value)))
    else $error("load strobe did not force the preset");

  // clear held over two edges keeps the count at zero
  clear_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (async_clear && $past(async_clear)) |-> (count_r == COUNT_ZERO))
    else $error("count not zero while clear held");

  // up step past the limit gives the remainder
  modulo_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (plain_cycle && inc_edge && !dec_edge && count_r <= wrap_limit && increment_size <= wrap_limit
      && ({1'b0, count_r} + {1'b0, increment_size}) > {1'b0, wrap_limit})
    |=> (async_clear
      || count_r == WIDTH'($past(count_r) + $past(increment_size) - $past(wrap_limit) - WIDTH'(1))))
    else $error("overflow did not give the remainder");

  // an edge under load is consumed and not replayed
  force_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!async_clear && load_strobe && (inc_edge || dec_edge) && load_value <= wrap_limit)
    ##1 (!async_clear && !load_strobe && !inc_edge && !dec_edge)
    |=> (async_clear || count_r == $past(load_value, 2)))
    else $error("edge under load changed the count");

  // edges on both requests at once cancel
  both_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
    (plain_cycle && inc_edge && dec_edge) |=> (async_clear || count_r == $past(count_r)))
    else $error("simultaneous edges changed the count");

  // down step inside the range subtracts the step size
  down_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (plain_cycle && dec_edge && !inc_edge && count_r <= wrap_limit && increment_size <= count_r)
    |=> (async_clear || count_r == WIDTH'($past(count_r) - $past(increment_size))))
    else $error("down step did not subtract the increment size");

  // down step below zero gives the remainder from the top
  down_mod_a: assert property (@(posedge clk) disable iff (!rst_n)
    (plain_cycle && dec_edge && !inc_edge && count_r <= wrap_limit && increment_size <= wrap_limit
      && increment_size > count_r)
    |=> (async_clear
      || count_r == WIDTH'($past(count_r) + $past(wrap_limit) + WIDTH'(1) - $past(increment_size))))
    else $error("underflow did not give the remainder");

  // a preset of any size still lands inside the range
  load_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!async_clear && load_strobe)
    |=> (async_clear || count_r <= $past(wrap_limit)))
    else $error("load left the count out of range");

  // once inside the range the count never leaves it under that limit
  range_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!async_clear && count_r <= wrap_limit)
    |=> (async_clear || count_r <= $past(wrap_limit)))
    else $error("count left the range under a steady limit");

  // clear seen at an edge means the count is already zero
  clear_now_a: assert property (@(posedge clk) disable iff (!rst_n)
    async_clear |-> (count_r == COUNT_ZERO))
    else $error("count not zero while clear active");

  // the last edge under clear left zero even with a load pending
  clear_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(async_clear) |-> (count_r == COUNT_ZERO))
    else $error("count not zero after clear released");

  // ----------------------------------------
  // coverage of the main scenarios
  // ----------------------------------------
  wrap_up_c:   cover property (@(posedge clk) disable iff (!rst_n)
    plain_cycle && inc_edge && !dec_edge && up_sum >= modulus);
  wrap_down_c: cover property (@(posedge clk) disable iff (!rst_n)
    plain_cycle && dec_edge && !inc_edge && cnt_m < step_m);
  load_c:      cover property (@(posedge clk) disable iff (!rst_n) load_strobe && inc_edge);
  clear_c:     cover property (@(posedge clk) disable iff (!rst_n) async_clear && load_strobe);
  hold_c:      cover property (@(posedge clk) disable iff (!rst_n) plain_cycle && increment_request && inc_prev_r);

endmodule : wsc_counter

/* tb/wsc_ctrl_model.sv */
`timescale 1ns/100ps
module wsc_ctrl_model (
  input  wire logic go,    // one event strobe
  input  wire logic dir,   // 1 up, 0 down
  input  wire logic both,  // raise both requests together
  output logic      inc,   // up request
  output logic      dec    // down request
);
  // one strobe gated by direction and its inverse, so no separate up/down logic
  assign inc = go & (dir | both);
  assign dec = go & (~dir | both);
endmodule : wsc_ctrl_model

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic        clk, rst_n, clr, ld, go, dir, both, inc, dec;  // stimulus and requests
  logic [7:0]  ldv, stp, lim, cnt, exp_v;                     // data and expected count
  logic [31:0] ldv_w, lim_w, cnt_w;                           // wide preset, limit and count
  int          errors, check_count;                           // tallies
  wsc_counter #(.WIDTH(8)) i_dut (.clk(clk), .rst_n(rst_n), .async_clear(clr), .load_strobe(ld),
    .load_value(ldv), .increment_request(inc), .decrement_request(dec), .increment_size(stp),
    .wrap_limit(lim), .count_output(cnt));
  wsc_counter #(.WIDTH(32)) i_dut_w (.clk(clk), .rst_n(rst_n), .async_clear(clr), .load_strobe(ld),
    .load_value(ldv_w), .increment_request(inc), .decrement_request(dec), .increment_size({24'h000000, stp}),
    .wrap_limit(lim_w), .count_output(cnt_w));
  wsc_ctrl_model i_ctrl (.go(go), .dir(dir), .both(both), .inc(inc), .dec(dec));
  // ----------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // cut a hang short
  initial begin
    #20000;
    errors++;
    finish_test();
  end
  // expected next count, modulo limit plus one
  function automatic logic [7:0] nxt(input logic [7:0] c, s, l, input logic d);
    int m;
    m = int'(l) + 1;
    return d ? 8'((int'(c) + int'(s) % m) % m) : 8'((int'(c) + m - int'(s) % m) % m);
  endfunction : nxt
  task automatic chk(input logic [7:0] e);
    check_count++;
    if (cnt !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, cnt, e);
    end
  endtask : chk
  task automatic chk_w(input logic [31:0] e);
    check_count++;
    if (cnt_w !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, cnt_w, e);
    end
  endtask : chk_w
  // one event: strobe for one cycle, low for the next so the edge re-arms
  task automatic ev(input logic d, input logic [7:0] s);
    @(posedge clk);
    go <= 1'b1; dir <= d; stp <= s;
    @(posedge clk);
    go <= 1'b0;
    #1;
    exp_v = nxt(exp_v, s, lim, d);
  endtask : ev
  task automatic finish_test;
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0; clr = 1'b0; ld = 1'b0; go = 1'b0; dir = 1'b1; both = 1'b0;
    ldv = 8'h00; stp = 8'h0A; lim = 8'h32; exp_v = 8'h00; errors = 0; check_count = 0;
    ldv_w = 32'h0000_0000; lim_w = 32'h0000_0032;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(8'h00);
    // limit 50 step 10 runs 10..50 then 9
    repeat (6) begin
      ev(1'b1, 8'h0A); chk(exp_v);
    end
    ev(1'b0, 8'h0A); chk(8'h32);
    // held level counts once only
    @(posedge clk) go <= 1'b1; dir <= 1'b1;
    repeat (4) @(posedge clk);
    go <= 1'b0;
    #1 chk(8'h09);
    // load masks a request edge; the held request is not replayed after
    @(posedge clk) ld <= 1'b1; ldv <= 8'h21; go <= 1'b1;
    @(posedge clk) ld <= 1'b0;
    #1 chk(8'h21);
    @(posedge clk) go <= 1'b0;
    #1 chk(8'h21);
    // simultaneous edges
    @(posedge clk) go <= 1'b1; both <= 1'b1;
    @(posedge clk) go <= 1'b0; both <= 1'b0;
    #1 chk(8'h21);
    // clear acts before the next edge and beats a load
    @(posedge clk) clr <= 1'b1; ld <= 1'b1;
    #1 chk(8'h00);
    repeat (2) @(posedge clk);
    #1 chk(8'h00);
    @(posedge clk) clr <= 1'b0; ld <= 1'b0;
    #1 chk(8'h00);
    // full byte range wraps both ways
    @(posedge clk) lim <= 8'hFF; ld <= 1'b1; ldv <= 8'hFA; lim_w <= 32'hFFFF_FFFF; ldv_w <= 32'h0000_FFFA;
    @(posedge clk) ld <= 1'b0;
    exp_v = 8'hFA;
    ev(1'b1, 8'h0A); chk(exp_v);
    chk_w(32'h0001_0004);
    ev(1'b0, 8'h0A); chk(exp_v);
    chk_w(32'h0000_FFFA);
    ev(1'b1, 8'h05); chk(8'hFF);
    ev(1'b1, 8'h01); chk(8'h00);
    ev(1'b0, 8'h01); chk(8'hFF);
    finish_test();
  end
endmodule : testbench
